// *** rtl/oaspe_defines.vh ***
`ifndef OASPE_DEFINES_VH
`define OASPE_DEFINES_VH
// opcodes handled by this executor
`define OASPE_OP_OR_A_IMM 8'h44
`define OASPE_OP_OR_DIR_A 8'h42
`define OASPE_OP_OR_DIR_IMM 8'h43
`define OASPE_OP_OR_C_BIT 8'h72
`define OASPE_OP_OR_C_NBIT 8'hA0
`define OASPE_OP_POP 8'hD0
// machine cycles per instruction
`define OASPE_CYC_OR_A_IMM 2'h1
`define OASPE_CYC_OR_DIR_A 2'h1
`define OASPE_CYC_OR_DIR_IMM 2'h2
`define OASPE_CYC_OR_C_BIT 2'h2
`define OASPE_CYC_POP 2'h2
// direct address of the stack pointer register
`define OASPE_ADDR_STACK_POINTER 8'h81
// reset values
`define OASPE_RST_ACC 8'h00
`define OASPE_RST_STACK_POINTER 8'h07
`define OASPE_RST_PC 16'h0000
`endif

// *** rtl/oaspe_decode.v ***
`timescale 1ns/1ps
`default_nettype none
`include "oaspe_defines.vh"
// opcode to instruction class and length
module oaspe_decode (
  // opcode
  input wire [7:0] opcode_in,
  // decoded class
  output reg [2:0] cls_out,
  output reg [1:0] nbytes_out,
  output reg [1:0] ncyc_out,
  output reg valid_out
);
  // one-hot free class codes; unknown opcodes are skipped as one byte
  always @* begin
    cls_out = 3'h0;
    nbytes_out = 2'h1;
    ncyc_out = 2'h1;
    valid_out = 1'b1;
    case (opcode_in)
      `OASPE_OP_OR_A_IMM: begin
        cls_out = 3'h1;
        nbytes_out = 2'h2;
        ncyc_out = `OASPE_CYC_OR_A_IMM; // RULE1
      end
      `OASPE_OP_OR_DIR_A: begin
        cls_out = 3'h2;
        nbytes_out = 2'h2;
        ncyc_out = `OASPE_CYC_OR_DIR_A;
      end
      `OASPE_OP_OR_DIR_IMM: begin
        cls_out = 3'h3;
        nbytes_out = 2'h3;
        ncyc_out = `OASPE_CYC_OR_DIR_IMM; // RULE3
      end
      `OASPE_OP_OR_C_BIT: begin
        cls_out = 3'h4;
        nbytes_out = 2'h2;
        ncyc_out = `OASPE_CYC_OR_C_BIT; // RULE5
      end
      `OASPE_OP_OR_C_NBIT: begin
        cls_out = 3'h5;
        nbytes_out = 2'h2;
        ncyc_out = `OASPE_CYC_OR_C_BIT;
      end
      `OASPE_OP_POP: begin
        cls_out = 3'h6;
        nbytes_out = 2'h2;
        ncyc_out = `OASPE_CYC_POP; // RULE9
      end
      default: begin
        valid_out = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// *** rtl/oaspe_bitsel.v ***
`timescale 1ns/1ps
`default_nettype none
// bit address to byte address and bit value
module oaspe_bitsel (
  // bit address and fetched byte
  input wire [7:0] bitaddr_in,
  input wire [7:0] byte_in,
  input wire invert_in,
  // results
  output wire [7:0] byteaddr_out,
  output wire bit_out
);
  // low area maps to ram 0x20..0x2F, high area to sfr rows
  assign byteaddr_out = bitaddr_in[7] ? {bitaddr_in[7:3], 3'h0} :
    {4'h2, bitaddr_in[6:3]};
  // only the operand is complemented, never the stored bit
  assign bit_out = byte_in[bitaddr_in[2:0]] ^ invert_in; // RULE6
endmodule
`default_nettype wire

// *** rtl/oaspe_exec.v ***
// Summary of operation
// RULE1 - or immediate into accumulator, one cycle
// RULE2 - or accumulator into direct byte
// RULE3 - or immediate into direct byte, two cycles
// RULE4 - set carry if source bit one
// RULE5 - bit or opcode 0x72, two bytes, two cycles
// RULE6 - inverted form complements operand only
// RULE7 - bit or changes only the carry
// RULE8 - pop reads stack, decrements, stores direct
// RULE9 - pop opcode 0xD0, two bytes, two cycles
// RULE10 - pop into stack pointer: popped value wins
// RULE11 - pop changes no status flag
// RULE12 - byte or changes no status flag
// RULE13 - port operand read from output latch
// RULE14 - fetch opcode then operands, advance pc
`timescale 1ns/1ps
`default_nettype none
`include "oaspe_defines.vh"
module oaspe_exec (
  // clock and reset
  input wire mclk_in,
  input wire rst_in,
  // program memory
  output reg [15:0] prog_addr_out,
  input wire [7:0] prog_data_in,
  // data space (ram and sfr); reads are combinational
  output reg [7:0] data_addr_out,
  input wire [7:0] data_rdata_in,
  output reg data_latch_sel_out,
  output reg [7:0] data_wdata_out,
  output reg data_we_out,
  // core state
  output reg [7:0] acc_out,
  output reg carry_out,
  output reg [7:0] stack_pointer_out,
  output reg [15:0] pc_out,
  output wire busy_out,
  output reg done_out,
  output reg illegal_out
);
  localparam ST_FETCH = 3'h0;
  localparam ST_OPND1 = 3'h1;
  localparam ST_OPND2 = 3'h2;
  localparam ST_EXEC = 3'h3;
  localparam ST_WAIT = 3'h4;

  reg [2:0] state_q;
  reg [7:0] op_q;
  reg [7:0] b1_q;
  reg [7:0] b2_q;
  reg [1:0] cyc_q;
  reg [7:0] pop_val_q;
  wire [2:0] cls;
  wire [1:0] nbytes;
  wire [1:0] ncyc;
  wire op_valid;
  wire [7:0] bit_byteaddr;
  wire bit_val;
  wire [2:0] cur_cls;
  wire [1:0] cur_nbytes;

  // decode of the freshly fetched opcode
  oaspe_decode u_dec_new (
    .opcode_in(prog_data_in),
    .cls_out(cls),
    .nbytes_out(nbytes),
    .ncyc_out(ncyc),
    .valid_out(op_valid)
  );

  // decode of the held opcode for later states
  oaspe_decode u_dec_cur (
    .opcode_in(op_q),
    .cls_out(cur_cls),
    .nbytes_out(cur_nbytes),
    .ncyc_out(),
    .valid_out()
  );

  // bit operand for the carry forms
  oaspe_bitsel u_bit (
    .bitaddr_in(b1_q),
    .byte_in(data_rdata_in),
    .invert_in(cur_cls == 3'h5),
    .byteaddr_out(bit_byteaddr),
    .bit_out(bit_val)
  );

  assign busy_out = (state_q != ST_FETCH);

  // data-space address and write during execute and the second pop cycle
  always @* begin
    data_addr_out = 8'h00;
    data_wdata_out = 8'h00;
    data_we_out = 1'b0;
    // read-modify-write takes port operand from its latch
    data_latch_sel_out = (state_q == ST_EXEC) &&
      ((cur_cls == 3'h2) || (cur_cls == 3'h3)); // RULE13
    prog_addr_out = pc_out;
    if (state_q == ST_EXEC) begin
      case (cur_cls)
        3'h2: begin
          data_addr_out = b1_q;
          data_wdata_out = data_rdata_in | acc_out; // RULE2
          data_we_out = 1'b1;
        end
        3'h3: begin
          data_addr_out = b1_q;
          data_wdata_out = data_rdata_in | b2_q; // RULE3
          data_we_out = 1'b1;
        end
        3'h4, 3'h5: begin
          data_addr_out = bit_byteaddr; // read only, bit untouched
        end
        3'h6: begin
          data_addr_out = stack_pointer_out; // RULE8
        end
        default: begin
          data_addr_out = 8'h00;
        end
      endcase
    end else if (state_q == ST_WAIT && cur_cls == 3'h6) begin
      // second pop cycle stores into the destination
      data_addr_out = b1_q;
      data_wdata_out = pop_val_q; // RULE8
      data_we_out = (b1_q != `OASPE_ADDR_STACK_POINTER);
    end
  end

  // sequencer: fetch, operands, execute, pad to cycle count
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ST_FETCH;
      op_q <= 8'h00;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
      cyc_q <= 2'h0;
      pop_val_q <= 8'h00;
      acc_out <= `OASPE_RST_ACC;
      carry_out <= 1'b0;
      stack_pointer_out <= `OASPE_RST_STACK_POINTER;
      pc_out <= `OASPE_RST_PC;
      done_out <= 1'b0;
      illegal_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (state_q)
        ST_FETCH: begin
          // opcode first, then operands in order
          op_q <= prog_data_in; // RULE14
          pc_out <= pc_out + 16'h0001; // RULE14
          illegal_out <= ~op_valid;
          cyc_q <= ncyc;
          if (!op_valid) begin
            done_out <= 1'b1; // unknown opcode skipped as one byte
          end else if (nbytes == 2'h1) begin
            state_q <= ST_EXEC;
          end else begin
            state_q <= ST_OPND1;
          end
        end
        ST_OPND1: begin
          b1_q <= prog_data_in; // RULE14
          pc_out <= pc_out + 16'h0001;
          state_q <= (cur_nbytes == 2'h3) ? ST_OPND2 : ST_EXEC;
        end
        ST_OPND2: begin
          b2_q <= prog_data_in; // RULE14
          pc_out <= pc_out + 16'h0001;
          state_q <= ST_EXEC;
        end
        ST_EXEC: begin
          case (cur_cls)
            3'h1: begin
              acc_out <= acc_out | b1_q; // RULE1 RULE12
            end
            3'h4, 3'h5: begin
              // only carry ever changes, and only towards one
              if (bit_val) begin
                carry_out <= 1'b1; // RULE4 RULE7
              end
            end
            3'h6: begin
              pop_val_q <= data_rdata_in;
              stack_pointer_out <= stack_pointer_out - 8'h01; // RULE8 RULE11
            end
            default: begin
              carry_out <= carry_out;
            end
          endcase
          if (cyc_q > 2'h1) begin
            cyc_q <= cyc_q - 2'h1;
            state_q <= ST_WAIT;
          end else begin
            state_q <= ST_FETCH;
            done_out <= 1'b1;
          end
        end
        ST_WAIT: begin
          // decrement already done, so the popped value wins
          if (cur_cls == 3'h6 && b1_q == `OASPE_ADDR_STACK_POINTER) begin
            stack_pointer_out <= pop_val_q; // RULE10
          end
          state_q <= ST_FETCH;
          done_out <= 1'b1;
        end
        default: begin
          state_q <= ST_FETCH;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** sim/oaspe_exec_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module oaspe_exec_checker (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // watched ports
  input wire logic [15:0] prog_addr_out,
  input wire logic [7:0] prog_data_in,
  input wire logic data_we_out,
  input wire logic data_latch_sel_out,
  input wire logic illegal_out,
  input wire logic [7:0] acc_out,
  input wire logic carry_out,
  input wire logic [15:0] pc_out,
  input wire logic busy_out,
  input wire logic done_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // opcode is taken only while busy is low
  wire logic f = !busy_out;
  wire logic [7:0] op = prog_data_in;
  pc_fetch_a: assert property (prog_addr_out == pc_out)
    else $error("bad fetch address");
  // back-to-back unknown opcodes may pulse done on consecutive cycles
  done_fetch_a: assert property (done_out |-> f ##1 (!done_out || illegal_out))
    else $error("bad done");
  imm_time_a: assert property (f && op == 8'h44 |=> busy_out[*2] ##1 done_out)
    else $error("bad timing");
  dimm_time_a: assert property (f && op == 8'h43 |=> busy_out[*4] ##1 done_out)
    else $error("bad timing");
  bit_time_a: assert property (f && (op == 8'h72 || op == 8'hA0) |=>
    busy_out[*3] ##1 done_out)
    else $error("bad timing");
  pop_time_a: assert property (f && op == 8'hD0 |=> busy_out[*3] ##1 done_out)
    else $error("bad timing");
  carry_sticky_a: assert property (!$fell(carry_out))
    else $error("carry cleared");
  acc_or_a: assert property ($changed(acc_out) |-> (acc_out & $past(acc_out)) == $past(acc_out))
    else $error("acc bit cleared");
  we_pulse_a: assert property (data_we_out |-> busy_out ##1 !data_we_out)
    else $error("bad write strobe");
  latch_sel_a: assert property (data_latch_sel_out |-> data_we_out && busy_out)
    else $error("latch select outside write");
  pc_step_a: assert property ($changed(pc_out) |-> pc_out == $past(pc_out) + 16'h0001)
    else $error("pc jumped");
  cover property (data_we_out);
  cover property ($rose(carry_out));
  cover property (f && op == 8'hA0);
endmodule
bind oaspe_exec oaspe_exec_checker u_chk (.mclk_in(mclk_in), .rst_in(rst_in),
  .prog_addr_out(prog_addr_out), .prog_data_in(prog_data_in), .data_we_out(data_we_out),
  .data_latch_sel_out(data_latch_sel_out), .illegal_out(illegal_out),
  .acc_out(acc_out), .carry_out(carry_out), .pc_out(pc_out), .busy_out(busy_out),
  .done_out(done_out));
`default_nettype wire

// *** sim/oaspe_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
module oaspe_mem (
  // clock
  input wire logic mclk_in,
  // program and data space
  input wire logic [15:0] prog_addr_in,
  output logic [7:0] prog_data_out,
  input wire logic [7:0] data_addr_in,
  output logic [7:0] data_rdata_out,
  input wire logic data_we_in,
  input wire logic [7:0] data_wdata_in
);
  logic [7:0] pmem [0:255];
  logic [7:0] dmem [0:255];
  // reads same cycle; program wraps at 256 bytes to keep the model small
  assign prog_data_out = pmem[prog_addr_in[7:0]];
  assign data_rdata_out = dmem[data_addr_in];
  // latch and pins are one store here
  always @(posedge mclk_in) begin
    if (data_we_in) begin
      dmem[data_addr_in] <= data_wdata_in;
    end
  end
endmodule
`default_nettype wire

// *** sim/test_or_and_stack_pop_execution.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_or_and_stack_pop_execution;
  logic mclk_in;
  logic rst_in;
  wire logic [15:0] pa, pc;
  wire logic [7:0] pd, da, rd, wd, acc, sp;
  wire logic we, ls, cy, busy, done, ill;
  integer bad_count, tests_run, i, k, a, n, mpc, lsn, mls;
  logic [15:0] r;
  logic [7:0] op, b1, v, macc, msp, mc;
  logic [7:0] p [0:255];
  logic [7:0] ram [0:255];
  oaspe_exec u_oaspe_exec (.mclk_in(mclk_in), .rst_in(rst_in), .prog_addr_out(pa),
    .prog_data_in(pd), .data_addr_out(da), .data_rdata_in(rd), .data_latch_sel_out(ls),
    .data_wdata_out(wd), .data_we_out(we), .acc_out(acc), .carry_out(cy),
    .stack_pointer_out(sp), .pc_out(pc), .busy_out(busy), .done_out(done), .illegal_out(ill));
  oaspe_mem u_oaspe_mem (.mclk_in(mclk_in), .prog_addr_in(pa), .prog_data_out(pd),
    .data_addr_in(da), .data_rdata_out(rd), .data_we_in(we), .data_wdata_in(wd));
  function [15:0] lfsr(input [15:0] x);
    lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task chk(input [15:0] seen, input [15:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("ERROR %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    mclk_in = 0;
    forever #25 mclk_in = ~mclk_in;
  end
  // 40 instructions need under 250 cycles
  initial begin
    #(2000 * 50);
    bad_count = bad_count + 1;
    results;
  end
  initial begin
    rst_in = 1;
    bad_count = 0;
    tests_run = 0;
    r = 16'hD603;
    a = 0;
    // ram kept below 80h so a popped stack pointer stays in ram
    for (i = 0; i < 256; i = i + 1) begin
      r = lfsr(r);
      ram[i] = r[7:0] & 8'h7F;
      p[i] = 8'hA5;
    end
    // random program, A5h is unsupported
    for (k = 0; k < 40; k = k + 1) begin
      r = lfsr(r);
      op = r[2:0] == 0 ? 8'h44 : r[2:0] == 1 ? 8'h42 : r[2:0] == 2 ? 8'h43 :
        r[2:0] == 3 ? 8'h72 : r[2:0] == 4 ? 8'hA0 : r[2:0] == 5 ? 8'hA5 : 8'hD0;
      b1 = op[5] ? {1'b0, r[14:8]} : op[7] && r[15:14] == 0 ? 8'h81 : 8'h30 + r[13:8];
      p[a] = op;
      p[a + 1] = b1;
      p[a + 2] = ~r[7:0];
      a = a + (op == 8'h43 ? 3 : op == 8'hA5 ? 1 : 2);
    end
    for (i = 0; i < 256; i = i + 1) begin
      u_oaspe_mem.pmem[i] = p[i];
      u_oaspe_mem.dmem[i] = ram[i];
    end
    repeat (6) @(posedge mclk_in);
    rst_in <= 0;
    macc = 0;
    mc = 0;
    msp = 8'h07;
    mpc = 0;
    lsn = 0;
    mls = 0;
    // model steps one instruction per done pulse
    for (k = 0; k < 40; k = k + 1) begin
      n = 0;
      do begin
        @(negedge mclk_in);
        n = n + 1;
        if (ls === 1'b1) lsn = lsn + 1;
      end while (done !== 1'b1 && n < 20);
      op = p[mpc];
      b1 = p[mpc + 1];
      case (op)
        8'h44: macc = macc | b1;
        8'h42: ram[b1] = ram[b1] | macc;
        8'h43: ram[b1] = ram[b1] | p[mpc + 2];
        8'h72, 8'hA0: begin
          v = ram[8'h20 + b1[6:3]];
          if (v[b1[2:0]] ^ op[7]) mc = 1;
        end
        8'hD0: begin
          v = ram[msp];
          msp = msp - 1;
          if (b1 == 8'h81) msp = v;
          else ram[b1] = v;
        end
        default: ;
      endcase
      mpc = mpc + (op == 8'h43 ? 3 : op == 8'hA5 ? 1 : 2);
      chk(acc, macc);
      chk(cy, mc);
      chk(sp, msp);
      chk(pc, mpc[15:0]);
      chk(ill, op == 8'hA5);
      // only the read-modify-write byte forms (42h, 43h) read the port latch, not pop
      if (op == 8'h42 || op == 8'h43) mls = mls + 1;
      chk(lsn, mls);
      // first instruction also waits out the edge that releases reset
      if (op != 8'hA5) chk(n, (k == 0) + (op == 8'h43 ? 5 : op[4] || op[7] ? 4 : 3));
    end
    for (i = 0; i < 256; i = i + 1) begin
      chk(u_oaspe_mem.dmem[i], ram[i]);
    end
    results;
  end
endmodule
`default_nettype wire
